/* File: dv/axh_drive_model.sv */
// drive-side model: standstill flag and switch pins
`timescale 1ns/1ns
module axh_drive_model
    import axh_pkg::*;
(
    // clock
    input wire logic core_clk,
    // motion request and test controls
    input axh_drv_t drv_cmd,
    input wire logic stall,
    input wire logic moving,
    // pins toward the block
    output logic axis_standstill,
    output logic fwd_limit_in,
    output logic rev_limit_in,
    output logic ref_switch_in,
    output logic index_pulse_in
);
    logic [7:0] cnt_q;
    logic fwd_q;
    // travel counter restarts on stop and on each reversal
    always_ff @(posedge core_clk) begin
        fwd_q <= drv_cmd.fwd;
        if (!drv_cmd.run || drv_cmd.fwd != fwd_q) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'hFF) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    // standstill only while no motion is requested
    assign axis_standstill = !drv_cmd.run && !moving;
    // forward limit met after a short travel, stall hides every switch
    assign fwd_limit_in = drv_cmd.run && drv_cmd.fwd && !stall && cnt_q >= 8'h08;
    // index held five cycles, longer than one scan
    assign index_pulse_in = drv_cmd.run && !drv_cmd.fwd && !stall
        && cnt_q >= 8'h08 && cnt_q < 8'h0D;
    assign rev_limit_in = 1'b0;
    assign ref_switch_in = 1'b0;
endmodule

/* File: dv/axh_homing_checker.sv */
// port assertions for the homing command block
`timescale 1ns/1ns
module axh_homing_checker
    import axh_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register bus
    input axh_apb_req_t apb_req,
    input axh_apb_rsp_t apb_rsp,
    // drive side and flags
    input axh_drv_t drv_cmd,
    input logic [31:0] axis_position,
    input axh_stat_t cmd_stat
);
    logic wr_ctrl;
    logic trig_q;
    logic wr_home;
    logic [31:0] home_sh;
    logic [31:0] home_cap_q;
    // shadow of the trigger bit written over the bus
    assign wr_ctrl = apb_req.psel && apb_req.penable && apb_req.pwrite
        && apb_req.paddr == AXH_ADDR_CTRL;
    assign wr_home = apb_req.psel && apb_req.penable && apb_req.pwrite
        && apb_req.paddr == AXH_ADDR_HOME;
    // shadow of the home value, copied when a trigger rise is written while idle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            trig_q <= 1'b0;
            home_sh <= AXH_HOME_RST;
            home_cap_q <= AXH_HOME_RST;
        end else begin
            if (wr_ctrl) begin
                trig_q <= apb_req.pwdata[AXH_CTRL_TRIG];
            end
            if (wr_home) begin
                home_sh <= apb_req.pwdata;
            end
            if (wr_ctrl && apb_req.pwdata[AXH_CTRL_TRIG] && !trig_q
                    && !cmd_stat.busy) begin
                home_cap_q <= home_sh;
            end
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_rise_wr;
        wr_ctrl && apb_req.pwdata[AXH_CTRL_TRIG] && !trig_q;
    endsequence
    sequence s_fall_wr;
        wr_ctrl && !apb_req.pwdata[AXH_CTRL_TRIG] && trig_q;
    endsequence
    sequence s_answer;
        ##[1:3] (cmd_stat.busy || cmd_stat.fault || cmd_stat.done);
    endsequence
    AST_START: assert property (s_rise_wr |-> s_answer)
        else $error("no answer to trigger rise");
    AST_NO_SPUR: assert property ($rose(cmd_stat.busy) |-> trig_q
        && ($past(wr_ctrl) || $past(wr_ctrl, 2) || $past(wr_ctrl, 3)))
        else $error("busy without trigger rise");
    AST_TRIG_FALL: assert property (s_fall_wr |-> ##2 (!cmd_stat.busy
        && !cmd_stat.fault && cmd_stat.code == AXH_NO_FAULT_VALUE))
        else $error("flags not cleared on trigger low");
    AST_CODE: assert property (cmd_stat.fault == (cmd_stat.code != AXH_NO_FAULT_VALUE))
        else $error("fault code and fault flag disagree");
    AST_FAULT_IDLE: assert property (cmd_stat.fault |-> !cmd_stat.busy && !cmd_stat.done)
        else $error("busy or done with fault");
    AST_DONE_PULSE: assert property ($rose(cmd_stat.done) && !trig_q && !$past(trig_q)
        |=> !cmd_stat.done)
        else $error("done longer than one cycle with trigger low");
    AST_ABORT_PULSE: assert property ($rose(cmd_stat.abort) && !trig_q && !$past(trig_q)
        |=> !cmd_stat.abort)
        else $error("aborted longer than one cycle with trigger low");
    AST_DONE_LOAD: assert property ($rose(cmd_stat.done) |-> drv_cmd.pos_load
        && axis_position == home_cap_q ##1 !drv_cmd.pos_load)
        else $error("position not loaded at completion");
    AST_RUN_BUSY: assert property ($fell(drv_cmd.run) |-> cmd_stat.done
        || cmd_stat.abort || !trig_q)
        else $error("motion stopped without an ending");
    AST_HOLD_DONE: assert property (cmd_stat.done && trig_q && !wr_ctrl |=> cmd_stat.done)
        else $error("done dropped with trigger high");
endmodule
bind axh_homing axh_homing_checker i_chk (
    .core_clk(core_clk),
    .srst(srst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .drv_cmd(drv_cmd),
    .axis_position(axis_position),
    .cmd_stat(cmd_stat)
);

/* File: dv/tb_top.sv */
// self-checking bench for the axis homing command block
`timescale 1ns/1ns
module tb_top;
    import axh_pkg::*;
    logic core_clk, srst, stall, moving, err;
    logic fwd_w, rev_w, ref_w, ix_w, still_w;
    axh_apb_req_t apb_req;
    axh_apb_rsp_t apb_rsp;
    axh_drv_t drv_cmd;
    logic [31:0] axis_position, rd;
    axh_stat_t cmd_stat;
    int fail_count, compares;
    // clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    axh_homing i_dut (.core_clk(core_clk), .srst(srst), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .fwd_limit_in(fwd_w), .rev_limit_in(rev_w),
        .ref_switch_in(ref_w), .index_pulse_in(ix_w), .axis_standstill(still_w),
        .drv_cmd(drv_cmd), .axis_position(axis_position), .cmd_stat(cmd_stat));
    axh_drive_model i_drv (.core_clk(core_clk), .drv_cmd(drv_cmd), .stall(stall),
        .moving(moving), .axis_standstill(still_w), .fwd_limit_in(fwd_w),
        .rev_limit_in(rev_w), .ref_switch_in(ref_w), .index_pulse_in(ix_w));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one apb transfer, setup then access until pready
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge core_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            tally_and_finish();
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    // wait for any flag in mask: b0 fault b1 abort b2 busy b3 done
    task automatic wait_flag(input logic [3:0] mask);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while ((cmd_stat[3:0] & mask) === 4'h0 && n < 400);
        if (n >= 400) begin
            fail_count++;
            tally_and_finish();
        end
    endtask
    task automatic cfg(input logic [7:0] m, input logic [31:0] spd, input logic [31:0] acc);
        apb(1'b1, AXH_ADDR_METH, {24'h0, m});
        apb(1'b1, AXH_ADDR_SPD, spd);
        apb(1'b1, AXH_ADDR_ACC, acc);
    endtask
    task automatic t_reset();
        logic [7:0] adr[4];
        adr = '{AXH_ADDR_HOME, AXH_ADDR_METH, AXH_ADDR_SPD, AXH_ADDR_ACC};
        chk("stat", 32'(cmd_stat), 32'h0);
        chk("pos", axis_position, 32'h0);
        foreach (adr[i]) begin
            apb(1'b0, adr[i], 32'h0);
            chk("reg", rd, 32'h0);
        end
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
        $display("reset test done");
    endtask
    task automatic t_home();
        apb(1'b1, AXH_ADDR_HOME, 32'hFFFF_FF9C);
        cfg(8'h02, 32'h0040_0100, 32'hBEEF_0020);
        apb(1'b1, AXH_ADDR_CTRL, 32'h1);
        wait_flag(4'h4);
        chk("drv", {drv_cmd.fwd, 15'h0, drv_cmd.speed}, 32'h8000_0100);
        chk("accel", 32'(drv_cmd.accel), 32'h20);
        wait_flag(4'h8);
        chk("pos", axis_position, 32'hFFFF_FF9C);
        apb(1'b1, AXH_ADDR_HOME, 32'h0);
        apb(1'b1, AXH_ADDR_CTRL, 32'h1);
        apb(1'b0, AXH_ADDR_POS, 32'h0);
        chk("pos rd", rd, 32'hFFFF_FF9C);
        chk("stat held", 32'(cmd_stat), 32'h8);
        apb(1'b1, AXH_ADDR_CTRL, 32'h0);
        repeat (2) @(posedge core_clk);
        #1;
        chk("stat low", 32'(cmd_stat), 32'h0);
        $display("home test done");
    endtask
    task automatic t_methods();
        logic [7:0] ml[3];
        ml = '{8'h21, 8'h23, 8'h12};
        foreach (ml[i]) begin
            apb(1'b1, AXH_ADDR_HOME, 32'h0000_0500 + ml[i]);
            cfg(ml[i], 32'h0040_0100, 32'h0020);
            apb(1'b1, AXH_ADDR_CTRL, 32'h1);
            if (i == 0) begin
                wait_flag(4'h4);
                chk("ix drv", {drv_cmd.fwd, 15'h0, drv_cmd.speed}, 32'h0000_0040);
            end
            wait_flag(4'h9);
            chk("method pos", axis_position, 32'h0000_0500 + ml[i]);
            apb(1'b1, AXH_ADDR_CTRL, 32'h0);
        end
        $display("method test done");
    endtask
    task automatic t_faults();
        logic [7:0] ml[4], cd[4];
        logic [31:0] sp[4];
        ml = '{8'h00, 8'h0F, 8'h02, 8'h02};
        sp = '{32'h0001_0001, 32'h0001_0001, 32'h0001_0000, 32'h0001_0001};
        cd = '{AXH_FLT_BAD_METHOD, AXH_FLT_BAD_METHOD, AXH_FLT_BAD_SPEED, AXH_FLT_NOT_STILL};
        foreach (ml[i]) begin
            moving <= (i == 3);
            cfg(ml[i], sp[i], 32'h0020);
            apb(1'b1, AXH_ADDR_CTRL, 32'h1);
            wait_flag(4'hF);
            chk("fault", 32'(cmd_stat), {20'h0, cd[i], 4'h1});
            apb(1'b0, AXH_ADDR_STAT, 32'h0);
            chk("stat rd", {rd[15:8], rd[4], rd[3]}, {cd[i], 1'(i != 3), 1'b1});
            apb(1'b1, AXH_ADDR_CTRL, 32'h0);
            repeat (2) @(posedge core_clk);
            #1;
            chk("cleared", 32'(cmd_stat), 32'h0);
        end
        moving <= 1'b0;
        $display("fault test done");
    endtask
    task automatic t_abort();
        stall <= 1'b1;
        cfg(8'h02, 32'h0040_0100, 32'h0020);
        apb(1'b1, AXH_ADDR_CTRL, 32'h1);
        wait_flag(4'h4);
        apb(1'b1, AXH_ADDR_CTRL, 32'h3);
        wait_flag(4'h2);
        repeat (3) @(posedge core_clk);
        #1;
        chk("aborted", 32'(cmd_stat), 32'h2);
        apb(1'b0, AXH_ADDR_CTRL, 32'h0);
        chk("ctrl rd", rd, 32'h1);
        apb(1'b1, AXH_ADDR_CTRL, 32'h0);
        repeat (2) @(posedge core_clk);
        #1;
        chk("abort clr", 32'(cmd_stat), 32'h0);
        stall <= 1'b0;
        $display("abort test done");
    endtask
    // timeout guard
    initial begin
        #800000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        srst = 1'b1;
        apb_req = '0;
        stall = 1'b0;
        moving = 1'b0;
        fail_count = 0;
        compares = 0;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        #1;
        t_reset();
        t_home();
        t_methods();
        t_faults();
        t_abort();
        tally_and_finish();
    end
endmodule

/* File: hdl/axh_homing.sv */
// axis homing command block with apb register slave
`timescale 1ns/1ns
module axh_homing
    import axh_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register bus
    input axh_apb_req_t apb_req,
    output axh_apb_rsp_t apb_rsp,
    // switch pins: fwd limit, rev limit, ref switch, index pulse
    input wire logic fwd_limit_in,
    input wire logic rev_limit_in,
    input wire logic ref_switch_in,
    input wire logic index_pulse_in,
    // axis drive side
    input wire logic axis_standstill,
    output axh_drv_t drv_cmd,
    output logic [31:0] axis_position,
    // command flags
    output axh_stat_t cmd_stat
);
    typedef struct packed {
        axh_state_t st;
        logic cmd_trigger;
        logic trig_prev;
        logic stop_pend;
        logic [31:0] home_position_value;
        logic [7:0] homing_method_sel;
        logic [15:0] switch_search_speed;
        logic [15:0] index_search_speed;
        logic [15:0] homing_accel;
        logic [15:0] homing_decel;
        logic [31:0] home_cap;
        logic [15:0] sw_spd_cap;
        logic [15:0] ix_spd_cap;
        logic [15:0] acc_cap;
        axh_meth_t meth;
        logic [3:0] sw_cap;
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] filt;
        logic ix_prev;
        logic done;
        logic busy;
        logic abort;
        logic fault;
        logic [7:0] fault_code;
        logic fwd;
        logic pos_load;
        logic [31:0] axis_pos;
        logic [31:0] prdata;
    } axh_reg_t;

    axh_reg_t r_q;
    axh_reg_t r_d;

    // homing mode table, reduced set of the standard modes
    function automatic axh_meth_t meth_decode(input logic [7:0] m);
        axh_meth_t d;
        logic [7:0] b;
        d = '{valid: 1'b1, sel: AXH_SEL_NONE, fwd: 1'b0, use_ix: 1'b1};
        b = (m > 8'h10) ? m - 8'h10 : m;
        if (m > 8'h10 && m < 8'h1F) begin
            d.use_ix = 1'b0;
        end
        if (m == 8'h21 || m == 8'h22) begin
            d.fwd = m[1];
            d.sel = AXH_SEL_NONE;
        end else if (m == 8'h23 || m == 8'h25) begin
            d.use_ix = 1'b0;
        end else if (b == 8'h01) begin
            d.sel = AXH_SEL_REV;
        end else if (b == 8'h02) begin
            d.sel = AXH_SEL_FWD;
            d.fwd = 1'b1;
        end else if (b >= 8'h03 && b <= 8'h0E && m != 8'h0F && m != 8'h10) begin
            d.sel = AXH_SEL_REF;
            d.fwd = (b <= 8'h0A);
        end else begin
            d.valid = 1'b0;
        end
        return d;
    endfunction

    // true when the method's selected switch is active in vector v
    function automatic logic sw_hit(input axh_sel_t s, input logic [3:0] v);
        logic h;
        h = 1'b0;
        unique case (s)
            AXH_SEL_FWD: h = v[AXH_SW_FWD];
            AXH_SEL_REV: h = v[AXH_SW_REV];
            AXH_SEL_REF: h = v[AXH_SW_REF];
            AXH_SEL_NONE: h = 1'b0;
        endcase
        return h;
    endfunction

    logic [3:0] pins;
    logic setup_ph;
    logic access_ph;
    logic mapped;
    assign pins = {index_pulse_in, ref_switch_in, rev_limit_in, fwd_limit_in};
    assign setup_ph = apb_req.psel & ~apb_req.penable;
    assign access_ph = apb_req.psel & apb_req.penable;
    assign mapped = (apb_req.paddr <= AXH_ADDR_POS) && (apb_req.paddr[1:0] == 2'b00);

    always_comb begin
        axh_meth_t m;
        logic rise;
        logic fall;
        logic ix_rise;
        logic finish;
        m = meth_decode(r_q.homing_method_sel);
        r_d = r_q;
        r_d.pos_load = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        ix_rise = 1'b0;
        finish = 1'b0;

        // three-stage pin sync, level taken once stages two and three agree
        r_d.s1 = pins;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        r_d.filt = (r_q.s2 & r_q.s3) | (r_q.filt & (r_q.s2 | r_q.s3));
        r_d.ix_prev = r_q.filt[AXH_SW_IX];
        ix_rise = r_q.filt[AXH_SW_IX] & ~r_q.ix_prev;

        // apb writes at the access phase, read data latched at setup
        if (access_ph && apb_req.pwrite) begin
            unique case (apb_req.paddr)
                AXH_ADDR_CTRL: begin
                    r_d.cmd_trigger = apb_req.pwdata[AXH_CTRL_TRIG];
                    r_d.stop_pend = apb_req.pwdata[AXH_CTRL_STOP];
                end
                AXH_ADDR_HOME: r_d.home_position_value = apb_req.pwdata;
                AXH_ADDR_METH: r_d.homing_method_sel = apb_req.pwdata[7:0];
                AXH_ADDR_SPD: begin
                    r_d.switch_search_speed = apb_req.pwdata[15:0];
                    r_d.index_search_speed = apb_req.pwdata[31:16];
                end
                AXH_ADDR_ACC: begin
                    r_d.homing_accel = apb_req.pwdata[15:0];
                    r_d.homing_decel = apb_req.pwdata[31:16]; // stored and read back, never used for motion
                end
                default: ;
            endcase
        end
        if (setup_ph) begin
            r_d.prdata = '0;
            unique case (apb_req.paddr)
                AXH_ADDR_CTRL: r_d.prdata[AXH_CTRL_TRIG] = r_q.cmd_trigger;
                AXH_ADDR_HOME: r_d.prdata = r_q.home_position_value;
                AXH_ADDR_METH: r_d.prdata[7:0] = r_q.homing_method_sel;
                AXH_ADDR_SPD: r_d.prdata = {r_q.index_search_speed, r_q.switch_search_speed};
                AXH_ADDR_ACC: r_d.prdata = {r_q.homing_decel, r_q.homing_accel};
                AXH_ADDR_STAT: begin
                    r_d.prdata[AXH_ST_DONE] = r_q.done;
                    r_d.prdata[AXH_ST_BUSY] = r_q.busy;
                    r_d.prdata[AXH_ST_ABORT] = r_q.abort;
                    r_d.prdata[AXH_ST_FAULT] = r_q.fault;
                    r_d.prdata[AXH_ST_STILL] = axis_standstill;
                    r_d.prdata[AXH_ST_CODE +: 8] = r_q.fault_code;
                end
                AXH_ADDR_POS: r_d.prdata = r_q.axis_pos;
                default: ;
            endcase
        end

        // trigger edges, the write above lands next cycle
        r_d.trig_prev = r_q.cmd_trigger;
        rise = r_q.cmd_trigger & ~r_q.trig_prev;
        fall = ~r_q.cmd_trigger & r_q.trig_prev;

        // flags that hold only for one cycle once the trigger is low
        if (!r_q.cmd_trigger && r_q.done) begin
            r_d.done = 1'b0;
        end
        if (!r_q.cmd_trigger && r_q.abort) begin
            r_d.abort = 1'b0;
        end
        if (fall) begin
            r_d.busy = 1'b0;
            r_d.fault = 1'b0;
            r_d.fault_code = AXH_NO_FAULT_VALUE;
            r_d.st = AXH_IDLE;
        end

        // start check and parameter capture
        if (rise && !r_q.busy) begin
            r_d.home_cap = r_q.home_position_value;
            r_d.sw_spd_cap = r_q.switch_search_speed;
            r_d.ix_spd_cap = r_q.index_search_speed;
            r_d.acc_cap = r_q.homing_accel;
            r_d.sw_cap = r_q.filt;
            r_d.meth = m;
            r_d.fwd = m.fwd;
            r_d.done = 1'b0;
            r_d.abort = 1'b0;
            if (!axis_standstill) begin
                r_d.fault = 1'b1;
                r_d.fault_code = AXH_FLT_NOT_STILL;
            end else if (!m.valid) begin
                r_d.fault = 1'b1;
                r_d.fault_code = AXH_FLT_BAD_METHOD;
            end else if ((m.sel != AXH_SEL_NONE && r_q.switch_search_speed == AXH_WORD_RST)
                    || (m.use_ix && r_q.index_search_speed == AXH_WORD_RST)) begin
                r_d.fault = 1'b1;
                r_d.fault_code = AXH_FLT_BAD_SPEED;
            end else if (m.sel != AXH_SEL_NONE) begin
                r_d.busy = 1'b1;
                r_d.st = AXH_SEEK_SW;
            end else if (m.use_ix) begin
                r_d.busy = 1'b1;
                r_d.st = AXH_SEEK_IX;
            end else begin
                r_d.busy = 1'b1;
                finish = 1'b1;
            end
        end else if (r_q.busy && !fall) begin
            // search sequence
            unique case (r_q.st)
                AXH_SEEK_SW: begin
                    if (sw_hit(r_q.meth.sel, r_q.filt | r_q.sw_cap)) begin
                        if (r_q.meth.use_ix) begin
                            r_d.st = AXH_SEEK_IX;
                            r_d.fwd = ~r_q.fwd; // back off the switch
                        end else begin
                            finish = 1'b1;
                        end
                    end
                end
                AXH_SEEK_IX: begin
                    if (ix_rise) begin
                        finish = 1'b1;
                    end
                end
                AXH_IDLE: finish = 1'b1;
            endcase
            r_d.sw_cap = '0;
            if (r_q.stop_pend && !finish) begin
                r_d.abort = 1'b1;
                r_d.busy = 1'b0;
                r_d.st = AXH_IDLE;
            end
        end

        // completion loads the home value into the axis position
        if (finish) begin
            r_d.done = 1'b1;
            r_d.busy = 1'b0;
            r_d.st = AXH_IDLE;
            r_d.axis_pos = r_d.home_cap;
            r_d.pos_load = 1'b1;
        end
        if (r_d.fault) begin
            r_d.done = 1'b0;
            r_d.busy = 1'b0;
        end
        if (!(access_ph && apb_req.pwrite && apb_req.paddr == AXH_ADDR_CTRL)) begin
            r_d.stop_pend = 1'b0;
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            r_q <= '0;
            r_q.st <= AXH_IDLE;
            r_q.home_position_value <= AXH_HOME_RST;
            r_q.homing_method_sel <= AXH_METH_RST;
            r_q.switch_search_speed <= AXH_WORD_RST;
            r_q.index_search_speed <= AXH_WORD_RST;
            r_q.homing_accel <= AXH_WORD_RST;
            r_q.homing_decel <= AXH_WORD_RST;
            r_q.fault_code <= AXH_NO_FAULT_VALUE;
        end else begin
            r_q <= r_d;
        end
    end

    // bus answer, zero wait states
    assign apb_rsp.prdata = r_q.prdata;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = access_ph & ~mapped;

    // drive request and flags
    assign drv_cmd.run = r_q.busy;
    assign drv_cmd.fwd = r_q.fwd;
    assign drv_cmd.speed = (r_q.st == AXH_SEEK_IX) ? r_q.ix_spd_cap : r_q.sw_spd_cap;
    assign drv_cmd.accel = r_q.acc_cap;
    assign drv_cmd.pos_load = r_q.pos_load;
    assign drv_cmd.pos_value = r_q.axis_pos;
    assign axis_position = r_q.axis_pos;
    assign cmd_stat.code = r_q.fault_code;
    assign cmd_stat.done = r_q.done;
    assign cmd_stat.busy = r_q.busy;
    assign cmd_stat.abort = r_q.abort;
    assign cmd_stat.fault = r_q.fault;
endmodule

/* File: hdl/axh_pkg.sv */
// constants, types and register map of the axis homing command block
// Functional notes
// - a homing run starts only on a rising edge of the trigger
// - home value, switches, method, speeds, accel captured on rise while not busy
// - on completion the axis position takes the captured home value
// - 8-bit method, 16-bit switch speed, index speed, accel, all default zero
// - complete rises at finish, drops on trigger low or fault
// - active rises with trigger except for methods 8'h23 and 8'h25, drops on completion, stop, trigger low or fault
// - aborted rises when a stop interrupts a run, clears on trigger low
// - aborted with trigger already low lasts exactly one cycle
// - invalid conditions or inputs raise fault and record a fault code
// - trigger low clears fault and fault code
// - fault code idles at no-fault value, all flags default low
// - command accepted only at standstill, otherwise a fault
// - method selects a homing mode and its search sequence
package axh_pkg;
    // register byte offsets
    localparam logic [7:0] AXH_ADDR_CTRL = 8'h00;
    localparam logic [7:0] AXH_ADDR_HOME = 8'h04;
    localparam logic [7:0] AXH_ADDR_METH = 8'h08;
    localparam logic [7:0] AXH_ADDR_SPD = 8'h0C;
    localparam logic [7:0] AXH_ADDR_ACC = 8'h10;
    localparam logic [7:0] AXH_ADDR_STAT = 8'h14;
    localparam logic [7:0] AXH_ADDR_POS = 8'h18;
    // control bits
    localparam int AXH_CTRL_TRIG = 0;
    localparam int AXH_CTRL_STOP = 1;
    // status field positions
    localparam int AXH_ST_DONE = 0;
    localparam int AXH_ST_BUSY = 1;
    localparam int AXH_ST_ABORT = 2;
    localparam int AXH_ST_FAULT = 3;
    localparam int AXH_ST_STILL = 4;
    localparam int AXH_ST_CODE = 8;
    // switch bit positions in the pin vector
    localparam int AXH_SW_FWD = 0;
    localparam int AXH_SW_REV = 1;
    localparam int AXH_SW_REF = 2;
    localparam int AXH_SW_IX = 3;
    // reset values
    localparam logic [31:0] AXH_HOME_RST = 32'h0000_0000;
    localparam logic [7:0] AXH_METH_RST = 8'h00;
    localparam logic [15:0] AXH_WORD_RST = 16'h0000;
    // fault codes
    localparam logic [7:0] AXH_NO_FAULT_VALUE = 8'h00;
    localparam logic [7:0] AXH_FLT_NOT_STILL = 8'h01;
    localparam logic [7:0] AXH_FLT_BAD_METHOD = 8'h02;
    localparam logic [7:0] AXH_FLT_BAD_SPEED = 8'h03;

    // switch that ends the first search phase
    typedef enum logic [1:0] {
        AXH_SEL_NONE = 2'h0,
        AXH_SEL_FWD = 2'h1,
        AXH_SEL_REV = 2'h2,
        AXH_SEL_REF = 2'h3
    } axh_sel_t;

    typedef enum logic [2:0] {
        AXH_IDLE = 3'b001,
        AXH_SEEK_SW = 3'b010,
        AXH_SEEK_IX = 3'b100
    } axh_state_t;

    typedef struct packed {
        logic valid;
        axh_sel_t sel;
        logic fwd;
        logic use_ix;
    } axh_meth_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } axh_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } axh_apb_rsp_t;

    // motion request toward the axis drive
    typedef struct packed {
        logic run;
        logic fwd;
        logic [15:0] speed;
        logic [15:0] accel;
        logic pos_load;
        logic [31:0] pos_value;
    } axh_drv_t;

    typedef struct packed {
        logic [7:0] code;
        logic done;
        logic busy;
        logic abort;
        logic fault;
    } axh_stat_t;
endpackage
